// ---- src/chg_pkg.sv ----
`default_nettype none
package chg_pkg;
   localparam int TW = 40;
   localparam int AW = 12;
   localparam int DW = 32;

   // register byte addresses
   localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [AW-1:0] ADDR_VOLT = 12'h004;
   localparam logic [AW-1:0] ADDR_CURR = 12'h008;
   localparam logic [AW-1:0] ADDR_STATUS = 12'h00c;

   // field positions
   localparam int CTRL_INLIM_LSB = 0;
   localparam int CTRL_TE = 2;
   localparam int CTRL_CV = 3;
   localparam int CTRL_STATEN = 4;
   localparam int VOLT_CODE_LSB = 0;
   localparam int VOLT_CEIL_LSB = 8;
   localparam int CURR_CODE_LSB = 0;
   localparam int ST_FAULT_LSB = 0;
   localparam int ST_IND_LSB = 4;
   localparam int ST_HOLD = 8;
   localparam int ST_SLEEP = 9;
   localparam int ST_SS = 10;
   localparam int ST_HOST = 11;

   // reset values
   localparam logic [1:0] RST_INLIM = 2'h0;
   localparam logic RST_TE = 1'h0;
   localparam logic RST_CV = 1'h0;
   localparam logic RST_STATEN = 1'h1;
   localparam logic [5:0] RST_VCODE = 6'h02;
   localparam logic [3:0] RST_CEIL = 4'h0;
   localparam logic [2:0] RST_ICODE = 3'h0;

   localparam logic [5:0] CEIL_BASE = 6'h23;
   localparam logic [1:0] INLIM_NOLIMIT = 2'h3;
   localparam logic [2:0] FOLDBACK_ICODE = 3'h0;

   // fault codes
   localparam logic [2:0] FLT_NONE = 3'h0;
   localparam logic [2:0] FLT_OVP = 3'h1;
   localparam logic [2:0] FLT_UV = 3'h3;
   localparam logic [2:0] FLT_BATOV = 3'h4;
   localparam logic [2:0] FLT_THERM = 3'h5;
   localparam logic [2:0] FLT_TIMER = 3'h6;
   localparam logic [2:0] FLT_NOBAT = 3'h7;

   // indicator codes
   localparam logic [1:0] IND_READY = 2'h0;
   localparam logic [1:0] IND_CHG = 2'h1;
   localparam logic [1:0] IND_DONE = 2'h2;
   localparam logic [1:0] IND_FAULT = 2'h3;

   // synchronised sense inputs
   localparam int I_FOLD = 0;
   localparam int I_CUT = 1;
   localparam int I_SLP = 2;
   localparam int I_UV = 3;
   localparam int I_RISE = 4;
   localparam int I_OVP = 5;
   localparam int I_OVPREL = 6;
   localparam int I_VALID = 7;
   localparam int I_PULSE = 8;
   localparam int I_TERM = 9;
   localparam int I_VRCH = 10;
   localparam int I_DEEP = 11;
   localparam int I_INS = 12;
   localparam int NSYNC = 13;

   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RETRY_MS = 2000;
   localparam int PULSE_US = 128;
   localparam int NOSW_MS = 30;
   localparam int READY_MS = 500;
   localparam int SS_MS = 1;
   localparam int NOBAT_MIN = 15;
   localparam logic [TW-1:0] CYC_PER_US = TW'(1000000 / CLK_PERIOD_PS);
   localparam logic [TW-1:0] CYC_PER_MS = CYC_PER_US * TW'(1000);
   localparam logic [TW-1:0] RETRY_CYC_DEF = TW'(RETRY_MS) * CYC_PER_MS;
   localparam logic [TW-1:0] PULSE_CYC_DEF = TW'(PULSE_US) * CYC_PER_US;
   localparam logic [TW-1:0] NOSW_CYC_DEF = TW'(NOSW_MS) * CYC_PER_MS;
   localparam logic [TW-1:0] READY_CYC_DEF = TW'(READY_MS) * CYC_PER_MS;
   localparam logic [TW-1:0] SS_CYC_DEF = TW'(SS_MS) * CYC_PER_MS;
   localparam logic [TW-1:0] NOBAT_CYC_DEF =
      TW'(NOBAT_MIN) * TW'(60000) * CYC_PER_MS;
   localparam logic [TW-1:0] PROBE_CYC_DEF = TW'(1000);
   localparam logic [TW-1:0] ONE = TW'(1);

   typedef enum logic [3:0] {
      ST_WAIT_VALID,
      ST_CHARGE,
      ST_UV_RETRY,
      ST_OVP,
      ST_PROBE,
      ST_READY,
      ST_DONE,
      ST_ABSENT_RETRY,
      ST_STOPPED
   } chg_state_t;
endpackage : chg_pkg
`default_nettype wire

// ---- src/chg_fault_ctrl.sv ----
// Implementation choices: the address map and register access over APB.
`default_nettype none
// Functional notes
// - voltage code clamped to 0x23 plus ceiling
// - foldback temperature forces 550 mA current code
// - cutoff suspends charging, fault 101, pulse
// - suspend freezes state and timers but the pin pulse; resume cooled
// - low input margin: sleep, block reverse current
// - input undervoltage: stop, indicator 11, fault 011
// - restart after recovery and two second retry
// - overvoltage: open pass switch, fault 001
// - overvoltage clears at release, then revalidate
// - no switching 30 ms with termination off: fault 100, pulse
// - termination: stop, indicator 10, probe sink
// - probe holds voltage: battery present, fault 000
// - probe drops: defaults, fault 111, retry later
// - deep discharge battery gets trickle source
// - batteryless default charge until host or timeout
// - raise triggers soft start, 100 mA limit
// - no limit code: 500 mA soft start
// - host sets CV flag; insertion clears it
// - pin open normally, low while charging enabled
// - any fault drives 128 us pin pulse
// - fault code held in status bits 2..0
// - after probe report 00 500 ms, then 10
module chg_fault_ctrl
   import chg_pkg::*;
#(
   parameter logic [TW-1:0] RETRY_CYC = RETRY_CYC_DEF,
   parameter logic [TW-1:0] PULSE_CYC = PULSE_CYC_DEF,
   parameter logic [TW-1:0] NOSW_CYC = NOSW_CYC_DEF,
   parameter logic [TW-1:0] READY_CYC = READY_CYC_DEF,
   parameter logic [TW-1:0] SS_CYC = SS_CYC_DEF,
   parameter logic [TW-1:0] NOBAT_CYC = NOBAT_CYC_DEF,
   parameter logic [TW-1:0] PROBE_CYC = PROBE_CYC_DEF
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [AW-1:0] PADDR,
   input wire logic [DW-1:0] PWDATA,
   output logic [DW-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // analog comparator levels, asynchronous
   input wire logic DIE_AT_FOLDBACK,
   input wire logic DIE_AT_CUTOFF,
   input wire logic VBUS_BELOW_SLEEP,
   input wire logic VBUS_BELOW_UV,
   input wire logic VBUS_ABOVE_RISE,
   input wire logic VBUS_ABOVE_OVP,
   input wire logic VBUS_BELOW_OVP_REL,
   input wire logic VBUS_VALIDATED,
   input wire logic SWITCH_PULSE,
   input wire logic TERM_CURRENT_SEEN,
   input wire logic VBAT_ABOVE_RECHARGE,
   input wire logic VBAT_BELOW_DEEP,
   input wire logic BATTERY_INSERTED,
   // power stage controls
   output logic CHARGE_ON,
   output logic INPUT_PASS_SWITCH_ON,
   output logic REVERSE_BLOCK_SWITCH_ON,
   output logic CURRENT_FOLDBACK,
   output logic TRICKLE_ON,
   output logic PROBE_SINK_ON,
   output logic SOFT_START_ACTIVE,
   output logic INPUT_LIMIT_100MA,
   output logic SOFT_START_500MA,
   output logic [5:0] CHARGE_VOLTAGE_EFF,
   output logic [2:0] CHARGE_CURRENT_EFF,
   output logic [1:0] INPUT_LIMIT_EFF,
   // open-drain indicator pin
   output logic IND_PIN_O,
   output logic IND_PIN_OE_N
);

   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic pulse_d;
   logic ins_d;
   chg_state_t state;
   chg_state_t next_state;
   logic [2:0] fault;
   logic [2:0] next_fault;
   logic [1:0] ind;
   logic [1:0] next_ind;
   logic hold;
   logic [1:0] inlim;
   logic te;
   logic cv;
   logic staten;
   logic [5:0] vcode;
   logic [3:0] ceil;
   logic [2:0] icode;
   logic host_active;
   logic [TW-1:0] tmr;
   logic [TW-1:0] tmr_val;
   logic tmr_load;
   logic [TW-1:0] nobat_cnt;
   logic [TW-1:0] nosw_cnt;
   logic nosw_fired;
   logic [TW-1:0] ss_cnt;
   logic [TW-1:0] pulse_cnt;
   logic fault_pulse;
   logic load_def;
   logic [DW-1:0] rd_status;
   logic [DW-1:0] rd_mux;

   // apb decode
   wire logic acc = PSEL & PENABLE;
   wire logic wr = acc & PWRITE;
   wire logic sel_ctrl = (PADDR == ADDR_CTRL);
   wire logic sel_volt = (PADDR == ADDR_VOLT);
   wire logic sel_curr = (PADDR == ADDR_CURR);
   wire logic sel_status = (PADDR == ADDR_STATUS);
   wire logic mapped = sel_ctrl | sel_volt | sel_curr | sel_status;
   wire logic wr_ctrl = wr & sel_ctrl;
   wire logic wr_volt = wr & sel_volt;
   wire logic wr_curr = wr & sel_curr;
   wire logic wr_any = wr & mapped;
   assign PREADY = 1'b1;
   assign PSLVERR = acc & ~mapped;

   // write fields
   wire logic [1:0] w_inlim = PWDATA[CTRL_INLIM_LSB +: 2];
   wire logic [5:0] w_vraw = PWDATA[VOLT_CODE_LSB +: 6];
   wire logic [3:0] w_ceil = PWDATA[VOLT_CEIL_LSB +: 4];
   wire logic [2:0] w_icode = PWDATA[CURR_CODE_LSB +: 3];
   wire logic [5:0] w_ceiling = CEIL_BASE + {2'h0, w_ceil};
   wire logic [5:0] ceiling = CEIL_BASE + {2'h0, ceil};
   // the ceiling written in the same word bounds the code at once
   wire logic [5:0] w_vcode =
      (w_vraw > w_ceiling) ? w_ceiling : w_vraw;
   // lowering the ceiling later also bounds the applied code
   wire logic [5:0] vcode_eff =
      (vcode > ceiling) ? ceiling : vcode;

   // soft start on any raised setting
   wire logic raise = (wr_volt & (w_vcode > vcode))
                    | (wr_ctrl & (w_inlim > inlim))
                    | (wr_curr & (w_icode > icode));
   wire logic ss_on = (ss_cnt != '0);

   // synchronised levels
   wire logic s_fold = sync2[I_FOLD];
   wire logic s_cut = sync2[I_CUT];
   wire logic s_slp = sync2[I_SLP];
   wire logic s_uv = sync2[I_UV];
   wire logic s_rise = sync2[I_RISE];
   wire logic s_ovp = sync2[I_OVP];
   wire logic s_ovprel = sync2[I_OVPREL];
   wire logic s_valid = sync2[I_VALID];
   wire logic s_term = sync2[I_TERM];
   wire logic s_vrch = sync2[I_VRCH];
   wire logic s_deep = sync2[I_DEEP];
   wire logic pulse_edge = sync2[I_PULSE] & ~pulse_d;
   wire logic ins_edge = sync2[I_INS] & ~ins_d;

   // events
   wire logic cut_ev = s_cut & ~hold;
   wire logic ovp_ev = s_ovp & (state != ST_OVP);
   wire logic charging = (state == ST_CHARGE);
   wire logic sleep = charging & s_slp & ~s_uv;
   wire logic charge_on = charging & ~hold & ~sleep;
   wire logic nobat_to = charging & ~host_active & (nobat_cnt == '0);
   wire logic batov_ev = charging & ~te & (nosw_cnt == '0) & ~nosw_fired;
   wire logic term_ev = charging & te & s_term & s_vrch;
   wire logic tmr_done = (tmr == '0);
   wire logic ind_drive = (pulse_cnt != '0) | (staten & charge_on);

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         sync1 <= '0;
         sync2 <= '0;
         pulse_d <= 1'b0;
         ins_d <= 1'b0;
      end
      else
      begin
         sync1 <= {BATTERY_INSERTED, VBAT_BELOW_DEEP, VBAT_ABOVE_RECHARGE,
                   TERM_CURRENT_SEEN, SWITCH_PULSE, VBUS_VALIDATED,
                   VBUS_BELOW_OVP_REL, VBUS_ABOVE_OVP, VBUS_ABOVE_RISE,
                   VBUS_BELOW_UV, VBUS_BELOW_SLEEP, DIE_AT_CUTOFF,
                   DIE_AT_FOLDBACK};
         sync2 <= sync1;
         pulse_d <= sync2[I_PULSE];
         ins_d <= sync2[I_INS];
      end
   end

   // configuration registers; default load wins over a host write
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || load_def)
      begin
         inlim <= RST_INLIM;
         te <= RST_TE;
         staten <= RST_STATEN;
         vcode <= RST_VCODE;
         ceil <= RST_CEIL;
         icode <= RST_ICODE;
      end
      else
      begin
         if (wr_ctrl)
         begin
            inlim <= w_inlim;
            te <= PWDATA[CTRL_TE];
            staten <= PWDATA[CTRL_STATEN];
         end
         if (wr_volt)
         begin
            vcode <= w_vcode;
            ceil <= w_ceil;
         end
         if (wr_curr)
            icode <= w_icode;
      end
   end

   // insertion beats a host write in the same cycle
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || load_def)
         cv <= RST_CV;
      else if (ins_edge)
         cv <= 1'b0;
      else if (wr_ctrl)
         cv <= PWDATA[CTRL_CV];
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || load_def)
         host_active <= 1'b0;
      else if (wr_any)
         host_active <= 1'b1;
   end

   // main sequencer
   always_comb
   begin
      next_state = state;
      next_fault = fault;
      next_ind = ind;
      fault_pulse = 1'b0;
      load_def = 1'b0;
      tmr_load = 1'b0;
      tmr_val = tmr;
      if (cut_ev)
      begin
         next_fault = FLT_THERM;
         fault_pulse = 1'b1;
      end
      else if (!hold)
      begin
         if (ovp_ev)
         begin
            next_state = ST_OVP;
            next_fault = FLT_OVP;
            next_ind = IND_FAULT;
            fault_pulse = 1'b1;
         end
         else
            unique case (state)
               ST_WAIT_VALID:
                  if (s_valid)
                  begin
                     next_state = ST_CHARGE;
                     next_ind = IND_CHG;
                  end
               ST_CHARGE:
                  if (s_uv)
                  begin
                     next_state = ST_UV_RETRY;
                     next_fault = FLT_UV;
                     next_ind = IND_FAULT;
                     fault_pulse = 1'b1;
                     tmr_load = 1'b1;
                     tmr_val = RETRY_CYC - ONE;
                  end
                  else if (nobat_to)
                  begin
                     next_state = ST_STOPPED;
                     next_fault = FLT_TIMER;
                     next_ind = IND_FAULT;
                     fault_pulse = 1'b1;
                  end
                  else if (term_ev)
                  begin
                     next_state = ST_PROBE;
                     next_ind = IND_DONE;
                     tmr_load = 1'b1;
                     tmr_val = PROBE_CYC - ONE;
                  end
                  else if (batov_ev)
                  begin
                     next_fault = FLT_BATOV;
                     next_ind = IND_FAULT;
                     fault_pulse = 1'b1;
                  end
               ST_UV_RETRY:
                  if (tmr_done && s_rise)
                     next_state = ST_WAIT_VALID;
               ST_OVP:
                  if (s_ovprel)
                     next_state = ST_WAIT_VALID;
               ST_PROBE:
                  if (tmr_done && s_vrch)
                  begin
                     next_state = ST_READY;
                     next_fault = FLT_NONE;
                     next_ind = IND_READY;
                     tmr_load = 1'b1;
                     tmr_val = READY_CYC - ONE;
                  end
                  else if (tmr_done)
                  begin
                     next_state = ST_ABSENT_RETRY;
                     next_fault = FLT_NOBAT;
                     next_ind = IND_FAULT;
                     fault_pulse = 1'b1;
                     load_def = 1'b1;
                     tmr_load = 1'b1;
                     tmr_val = RETRY_CYC - ONE;
                  end
               ST_READY:
                  if (tmr_done)
                  begin
                     next_state = ST_DONE;
                     next_ind = IND_DONE;
                  end
               ST_DONE:
                  if (!s_vrch)
                     next_state = ST_WAIT_VALID;
               ST_ABSENT_RETRY:
                  if (tmr_done)
                     next_state = ST_WAIT_VALID;
               ST_STOPPED:
                  if (wr_any)
                     next_state = ST_WAIT_VALID;
            endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         state <= ST_WAIT_VALID;
         fault <= FLT_NONE;
         ind <= IND_READY;
         hold <= 1'b0;
      end
      else
      begin
         state <= next_state;
         fault <= next_fault;
         ind <= next_ind;
         hold <= s_cut | (hold & s_fold);
      end
   end

   // timers; suspend freezes all but the pin pulse
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         tmr <= '0;
      else if (hold)
         tmr <= tmr;
      else if (tmr_load)
         tmr <= tmr_val;
      else if (!tmr_done)
         tmr <= tmr - ONE;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || load_def || host_active)
         nobat_cnt <= NOBAT_CYC - ONE;
      else if (charging && !hold && nobat_cnt != '0)
         nobat_cnt <= nobat_cnt - ONE;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || pulse_edge || !charging)
         nosw_cnt <= NOSW_CYC - ONE;
      else if (!hold && nosw_cnt != '0)
         nosw_cnt <= nosw_cnt - ONE;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET || pulse_edge || !charging)
         nosw_fired <= 1'b0;
      else if (batov_ev && !hold)
         nosw_fired <= 1'b1;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         ss_cnt <= '0;
      else if (raise)
         ss_cnt <= SS_CYC;
      else if (!hold && ss_on)
         ss_cnt <= ss_cnt - ONE;
   end

   // the pulse keeps running in suspend so the host still sees it
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         pulse_cnt <= '0;
      else if (fault_pulse)
         pulse_cnt <= PULSE_CYC;
      else if (pulse_cnt != '0)
         pulse_cnt <= pulse_cnt - ONE;
   end

   // read path, sampled in the setup cycle
   always_comb
   begin
      rd_status = '0;
      rd_status[ST_FAULT_LSB +: 3] = fault;
      rd_status[ST_IND_LSB +: 2] = ind;
      rd_status[ST_HOLD] = hold;
      rd_status[ST_SLEEP] = sleep;
      rd_status[ST_SS] = ss_on;
      rd_status[ST_HOST] = host_active;
      rd_mux = '0;
      if (sel_ctrl)
      begin
         rd_mux[CTRL_INLIM_LSB +: 2] = inlim;
         rd_mux[CTRL_TE] = te;
         rd_mux[CTRL_CV] = cv;
         rd_mux[CTRL_STATEN] = staten;
      end
      else if (sel_volt)
      begin
         rd_mux[VOLT_CODE_LSB +: 6] = vcode;
         rd_mux[VOLT_CEIL_LSB +: 4] = ceil;
      end
      else if (sel_curr)
         rd_mux[CURR_CODE_LSB +: 3] = icode;
      else if (sel_status)
         rd_mux = rd_status;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
         PRDATA <= '0;
      else if (PSEL && !PENABLE)
         PRDATA <= rd_mux;
   end

   // registered outputs
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         CHARGE_ON <= 1'b0;
         INPUT_PASS_SWITCH_ON <= 1'b0;
         REVERSE_BLOCK_SWITCH_ON <= 1'b0;
         CURRENT_FOLDBACK <= 1'b0;
         TRICKLE_ON <= 1'b0;
         PROBE_SINK_ON <= 1'b0;
         SOFT_START_ACTIVE <= 1'b0;
         INPUT_LIMIT_100MA <= 1'b0;
         SOFT_START_500MA <= 1'b0;
         CHARGE_VOLTAGE_EFF <= RST_VCODE;
         CHARGE_CURRENT_EFF <= RST_ICODE;
         INPUT_LIMIT_EFF <= RST_INLIM;
         IND_PIN_O <= 1'b0;
         IND_PIN_OE_N <= 1'b1;
      end
      else
      begin
         CHARGE_ON <= charge_on;
         INPUT_PASS_SWITCH_ON <= (state != ST_OVP);
         REVERSE_BLOCK_SWITCH_ON <= sleep;
         CURRENT_FOLDBACK <= s_fold;
         TRICKLE_ON <= charge_on & s_deep;
         PROBE_SINK_ON <= (state == ST_PROBE) & ~hold;
         SOFT_START_ACTIVE <= ss_on;
         INPUT_LIMIT_100MA <= ss_on & (inlim != INLIM_NOLIMIT);
         SOFT_START_500MA <= ss_on & (inlim == INLIM_NOLIMIT);
         CHARGE_VOLTAGE_EFF <= vcode_eff;
         CHARGE_CURRENT_EFF <= s_fold ? FOLDBACK_ICODE : icode;
         INPUT_LIMIT_EFF <= inlim;
         IND_PIN_O <= 1'b0;
         IND_PIN_OE_N <= ~ind_drive;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   a_voltage_ceiling: assert property (
      CHARGE_VOLTAGE_EFF <= CEIL_BASE + {2'h0, $past(ceil)})
      else $error("voltage code above ceiling");
   a_foldback_current: assert property (
      s_fold |=> CURRENT_FOLDBACK && CHARGE_CURRENT_EFF == FOLDBACK_ICODE)
      else $error("foldback current not applied");
   a_cutoff_fault: assert property (
      cut_ev |=> hold && fault == FLT_THERM && pulse_cnt == PULSE_CYC)
      else $error("cutoff fault not reported");
   a_suspend_freeze: assert property (
      hold && $past(hold) |-> tmr == $past(tmr) && state == $past(state))
      else $error("state moved while suspended");
   a_sleep_block: assert property (
      sleep |=> REVERSE_BLOCK_SWITCH_ON && !CHARGE_ON)
      else $error("sleep did not block reverse current");
   a_uv_fault: assert property (
      charging && !hold && !s_cut && !s_ovp && s_uv |=>
      state == ST_UV_RETRY && fault == FLT_UV && ind == IND_FAULT)
      else $error("undervoltage fault not taken");
   a_uv_retry: assert property (
      $past(state) == ST_UV_RETRY && state == ST_WAIT_VALID |->
      $past(tmr_done) && $past(s_rise))
      else $error("restart before retry interval");
   a_ovp_switch: assert property (
      ovp_ev && !hold && !s_cut |=> state == ST_OVP && fault == FLT_OVP
      ##1 !INPUT_PASS_SWITCH_ON)
      else $error("overvoltage did not open pass switch");
   a_probe_present: assert property (
      state == ST_PROBE && !hold && tmr_done && s_vrch && !s_cut && !s_ovp
      |=> state == ST_READY && fault == FLT_NONE && ind == IND_READY)
      else $error("present battery not reported");
   a_pulse_width: assert property (
      fault_pulse |-> ##2 !IND_PIN_OE_N [*8])
      else $error("fault pulse not driven");
   a_pin_open: assert property (
      !staten && pulse_cnt == '0 |=> IND_PIN_OE_N)
      else $error("indicator driven while disabled");

   c_probe_done: cover property (state == ST_READY ##1 state == ST_DONE);
   c_uv_retry: cover property (
      state == ST_UV_RETRY ##1 state == ST_WAIT_VALID);
   c_thermal: cover property (cut_ev ##[1:20] !hold);
   c_soft_start: cover property (raise && inlim == INLIM_NOLIMIT);

endmodule : chg_fault_ctrl
`default_nettype wire

// ---- verification/chg_host_pin.sv ----
`default_nettype none
module chg_host_pin
(
   // open-drain indicator from the device
   input wire logic PIN_O,
   input wire logic PIN_OE_N,
   // level seen at the host interrupt input
   output logic LEVEL
);
   timeunit 1ns;
   timeprecision 1ps;
   // board pull-up wins whenever the device lets go of the pin
   assign LEVEL = PIN_OE_N ? 1'b1 : PIN_O;
endmodule : chg_host_pin
`default_nettype wire

// ---- verification/chg_fault_ctrl_tb.sv ----
`default_nettype none
module chg_fault_ctrl_tb
   import chg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sw = 0;
   logic [AW-1:0] paddr = '0;
   logic [DW-1:0] pwdata = '0, prdata, r;
   logic pready, pslverr, e, chg_on, fold, pin_o, pin_oe_n, irq;
   logic pass_sw, rev;
   logic [5:0] veff;
   logic [NSYNC-1:0] sn = NSYNC'(1 << I_VALID) | NSYNC'(1 << I_RISE);
   int fail_count = 0, n_tests = 0;
   chg_fault_ctrl #(.RETRY_CYC(40'hc8), .PULSE_CYC(40'h10),
      .NOSW_CYC(40'h64), .READY_CYC(40'h32), .SS_CYC(40'h14),
      .NOBAT_CYC(40'h190), .PROBE_CYC(40'ha)) dut_u (
      .CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DIE_AT_FOLDBACK(sn[I_FOLD]),
      .DIE_AT_CUTOFF(sn[I_CUT]), .VBUS_BELOW_SLEEP(sn[I_SLP]),
      .VBUS_BELOW_UV(sn[I_UV]), .VBUS_ABOVE_RISE(sn[I_RISE]),
      .VBUS_ABOVE_OVP(sn[I_OVP]), .VBUS_BELOW_OVP_REL(sn[I_OVPREL]),
      .VBUS_VALIDATED(sn[I_VALID]), .SWITCH_PULSE(sw),
      .TERM_CURRENT_SEEN(sn[I_TERM]), .VBAT_ABOVE_RECHARGE(sn[I_VRCH]),
      .VBAT_BELOW_DEEP(sn[I_DEEP]), .BATTERY_INSERTED(sn[I_INS]),
      .CHARGE_ON(chg_on), .INPUT_PASS_SWITCH_ON(pass_sw),
      .CURRENT_FOLDBACK(fold),
      .REVERSE_BLOCK_SWITCH_ON(rev), .TRICKLE_ON(), .PROBE_SINK_ON(),
      .SOFT_START_ACTIVE(), .INPUT_LIMIT_100MA(), .SOFT_START_500MA(),
      .CHARGE_VOLTAGE_EFF(veff), .CHARGE_CURRENT_EFF(),
      .INPUT_LIMIT_EFF(), .IND_PIN_O(pin_o), .IND_PIN_OE_N(pin_oe_n));
   chg_host_pin host_u (.PIN_O(pin_o), .PIN_OE_N(pin_oe_n), .LEVEL(irq));
   initial forever #2 clk = ~clk;
   // keeps switching alive so the no-pulse fault stays out of the way
   always @(posedge clk) sw <= ~sw;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wait_on(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 1000)
      begin
         @(negedge clk);
         k++;
      end
      check(32'(s), 32'(v));
      @(posedge clk);
   endtask : wait_on
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic t_regs();
      apb(1'b0, ADDR_CTRL, '0);
      check(r, 32'h10);
      apb(1'b1, ADDR_VOLT, 32'h23f);
      apb(1'b0, ADDR_VOLT, '0);
      check(r, 32'h225);
      check(32'(veff), 32'h25);
      apb(1'b0, 12'h010, '0);
      check(32'(e), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h13);
      apb(1'b1, ADDR_VOLT, 32'h223);
      apb(1'b1, ADDR_CURR, 32'h4);
      apb(1'b1, ADDR_CTRL, 32'h11);
      check(32'(veff), 32'h23);
      wait_on(chg_on, 1'b1);
      check(32'(irq), 32'h0);
      $display("register test done");
   endtask : t_regs
   task automatic t_insert();
      apb(1'b1, ADDR_CTRL, 32'h09);
      apb(1'b0, ADDR_CTRL, '0);
      check(r, 32'h09);
      check(32'(irq), 32'h1);
      sn[I_INS] <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, ADDR_CTRL, '0);
      check(r, 32'h01);
      $display("insertion test done");
   endtask : t_insert
   task automatic t_ovp();
      sn[I_OVP] <= 1'b1;
      wait_on(chg_on, 1'b0);
      check(32'(pass_sw), 32'h0);
      apb(1'b0, ADDR_STATUS, '0);
      check(32'(r[5:0]), 32'h31);
      sn[I_OVP] <= 1'b0;
      sn[I_OVPREL] <= 1'b1;
      wait_on(chg_on, 1'b1);
      check(32'(pass_sw), 32'h1);
      $display("overvoltage test done");
   endtask : t_ovp
   task automatic t_sleep();
      sn[I_SLP] <= 1'b1;
      wait_on(chg_on, 1'b0);
      check(32'(rev), 32'h1);
      sn[I_SLP] <= 1'b0;
      wait_on(chg_on, 1'b1);
      check(32'(rev), 32'h0);
      $display("sleep test done");
   endtask : t_sleep
   task automatic t_uv();
      sn[I_UV] <= 1'b1;
      sn[I_RISE] <= 1'b0;
      wait_on(chg_on, 1'b0);
      check(32'(irq), 32'h0);
      apb(1'b0, ADDR_STATUS, '0);
      check(32'(r[5:0]), 32'h33);
      sn[I_UV] <= 1'b0;
      sn[I_RISE] <= 1'b1;
      wait_on(chg_on, 1'b1);
      check(32'(irq), 32'h1);
      $display("undervoltage test done");
   endtask : t_uv
   task automatic t_therm();
      sn[I_CUT] <= 1'b1;
      sn[I_FOLD] <= 1'b1;
      wait_on(chg_on, 1'b0);
      apb(1'b0, ADDR_STATUS, '0);
      check(32'({r[8], r[2:0]}), 32'hd);
      check(32'(fold), 32'h1);
      sn[I_CUT] <= 1'b0;
      sn[I_FOLD] <= 1'b0;
      wait_on(chg_on, 1'b1);
      $display("thermal test done");
   endtask : t_therm
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_insert();
      t_uv();
      t_therm();
      t_ovp();
      t_sleep();
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end
endmodule : chg_fault_ctrl_tb
`default_nettype wire
